// >>> design/fadc_params.svh
// Constants for the flash converter output latch.
`ifndef FADC_PARAMS_SVH
`define FADC_PARAMS_SVH
`define FADC_DATA_W     8
`define FADC_CODE_ZERO  8'h00
`define FADC_CODE_FULL  8'hff
`define FADC_BUF_DEPTH  2
`define FADC_PTR_W      1
`define FADC_CNT_W      2
`define FADC_OVR_RTZ    1'b1
`endif

// >>> design/fadc_pkg.sv
// Types shared by the flash converter output latch.
`include "fadc_params.svh"
package fadc_pkg;
   typedef struct packed {
      logic [`FADC_DATA_W-1:0] code;
      logic                    overrange;
   } fadc_word_s;
   typedef enum logic {
      FADC_PH_LOW,
      FADC_PH_HIGH
   } fadc_phase_e;
endpackage

// >>> design/fadc_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
`include "fadc_params.svh"
module fadc_buf2
   import fadc_pkg::*;
(
   // Clock and reset.
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   // Filling side.
   input  wire logic       i_in_valid,
   input  fadc_word_s      i_in_word,
   output logic            o_in_ready,
   // Draining side.
   output logic            o_out_valid,
   output fadc_word_s      o_out_word,
   input  wire logic       i_out_ready
);
   fadc_word_s                 mem_q [`FADC_BUF_DEPTH];
   logic [`FADC_PTR_W-1:0]     wr_q;
   logic [`FADC_PTR_W-1:0]     rd_q;
   logic [`FADC_CNT_W-1:0]     cnt_q;
   logic [`FADC_CNT_W-1:0]     cnt_d;
   wire                        push;
   wire                        pop;

   assign o_in_ready  = (cnt_q != `FADC_CNT_W'(`FADC_BUF_DEPTH));
   assign o_out_valid = (cnt_q != `FADC_CNT_W'(0));
   assign o_out_word  = mem_q[rd_q];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign cnt_d       = cnt_q + `FADC_CNT_W'(push) - `FADC_CNT_W'(pop);

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         mem_q <= '{default: '0};
      end else begin
         if (push) begin
            mem_q[wr_q] <= i_in_word;
            wr_q        <= wr_q + `FADC_PTR_W'(1);
         end
         if (pop) begin
            rd_q <= rd_q + `FADC_PTR_W'(1);
         end
         cnt_q <= cnt_d;
      end
   end
endmodule

// >>> design/fadc_latch.sv
// Output latch stage of a flash converter, strobed by a sampled strobe pair.
`timescale 1ns/1ns
`include "fadc_params.svh"
module fadc_latch
   import fadc_pkg::*;
(
   // Clock and reset.
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst_b,
   // Sample strobe pair and mode strap.
   input  wire logic                    i_sample_strobe,
   input  wire logic                    i_sample_strobe_n,
   input  wire logic                    i_overrange_mode_select,
   // Quantiser result for the current sample.
   input  wire logic [`FADC_DATA_W-1:0] i_conv_code,
   input  wire logic                    i_conv_at_top,
   // Latched outputs to the capture logic.
   output logic      [`FADC_DATA_W-1:0] o_result,
   output logic                         o_overrange,
   // Buffered stream of latched words.
   output logic                         o_word_valid,
   output fadc_word_s                   o_word,
   input  wire logic                    i_word_ready,
   output logic                         o_word_lost
);
   fadc_phase_e  phase_q;
   fadc_phase_e  phase_d;
   fadc_word_s   sample_q;
   fadc_word_s   sample_d;
   fadc_word_s   out_q;
   logic         lost_q;
   wire          strobe_rise;
   wire          pair_ok;
   wire          buf_ready;

   // An edge only counts while the pair is complementary; a glitch that
   // breaks the pair forces the low phase, so one in the high phase takes a second sample.
   assign pair_ok     = i_sample_strobe ^ i_sample_strobe_n;
   assign phase_d     = (pair_ok && i_sample_strobe) ? FADC_PH_HIGH
                                                     : FADC_PH_LOW;
   assign strobe_rise = (phase_q == FADC_PH_LOW) &&
                        (phase_d == FADC_PH_HIGH);

   function automatic fadc_word_s fadc_sample_strobe(
      input logic [`FADC_DATA_W-1:0] code,
      input logic                    at_top,
      input logic                    mode_rtz
   );
      fadc_word_s w;
      w.code      = code;
      w.overrange = 1'b0;
      if (at_top) begin
         if (mode_rtz == `FADC_OVR_RTZ) begin
            w.code      = `FADC_CODE_ZERO;
            w.overrange = 1'b1;
         end else begin
            w.code      = `FADC_CODE_FULL;
            w.overrange = 1'b0;
         end
      end
      return w;
   endfunction

   assign sample_d = fadc_sample_strobe(i_conv_code, i_conv_at_top,
                                 i_overrange_mode_select);

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase_q  <= FADC_PH_LOW;
         sample_q <= '0;
         out_q    <= '0;
         lost_q   <= 1'b0;
      end else begin
         phase_q <= phase_d;
         if (strobe_rise) begin
            sample_q <= sample_d;
            out_q    <= sample_q;
            lost_q   <= !buf_ready;
         end
      end
   end

   // Bit 0 of the bus is the least significant result bit.
   assign o_result    = out_q.code;
   assign o_overrange = out_q.overrange;
   assign o_word_lost = lost_q;

   // The buffer takes each newly latched word; the capture side may stall
   // for two strobe periods without loss, and a longer stall is flagged.
   fadc_buf2 u_buf (
      .i_mclk      (i_mclk),
      .i_rst_b     (i_rst_b),
      .i_in_valid  (strobe_rise),
      .i_in_word   (sample_q),
      .o_in_ready  (buf_ready),
      .o_out_valid (o_word_valid),
      .o_out_word  (o_word),
      .i_out_ready (i_word_ready)
   );
endmodule

// >>> testbench/fadc_cap.sv
// Strobe source and capture side stand-in.
`timescale 1ns/1ns
module fadc_cap (
   input  wire logic i_fire,
   input  wire logic i_stall,
   output logic      o_strobe,
   output logic      o_strobe_n,
   output logic      o_ready
);
   assign o_strobe   = i_fire;
   assign o_strobe_n = ~i_fire;
   assign o_ready    = ~i_stall;
endmodule

// >>> testbench/fadc_latch_assertions.sv
// Checker for the flash converter output latch.
`timescale 1ns/1ns
module fadc_chk
   import fadc_pkg::*;
(
   // Watched ports.
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   input  wire logic       i_sample_strobe,
   input  wire logic       i_sample_strobe_n,
   input  wire logic       i_overrange_mode_select,
   input  wire logic [7:0] i_conv_code,
   input  wire logic       i_conv_at_top,
   input  wire logic [7:0] o_result,
   input  wire logic       o_overrange,
   input  wire logic       o_word_valid,
   input  fadc_word_s      o_word
);
   logic       hi_q;
   logic [8:0] pend_q;
   wire        hi = i_sample_strobe & ~i_sample_strobe_n;
   wire        rise = hi & ~hi_q;
   wire  [8:0] now_w = !i_conv_at_top ? {i_conv_code, 1'b0} :
      i_overrange_mode_select ? 9'h001 : 9'h1fe;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hi_q   <= 1'b0;
         pend_q <= 9'h000;
      end else begin
         hi_q   <= hi;
         pend_q <= rise ? now_w : pend_q;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   sequence s_rise; rise; endsequence
   property p_lat; s_rise |=> {o_result, o_overrange} == $past(pend_q);
   endproperty
   a_lat: assert property (p_lat) else $error("bad word");
   property p_hold; !rise |=> $stable(o_result); endproperty
   a_hold: assert property (p_hold) else $error("moved");
   property p_rtz; o_overrange |-> o_result == 8'h00; endproperty
   a_rtz: assert property (p_rtz) else $error("rtz");
   property p_nrz; !i_overrange_mode_select |=> !$rose(o_overrange);
   endproperty
   a_nrz: assert property (p_nrz) else $error("nrz");
   property p_push; s_rise |=> o_word_valid; endproperty
   a_push: assert property (p_push) else $error("push");
   property p_word; $rose(o_word_valid) |->
      o_word == {o_result, o_overrange}; endproperty
   a_word: assert property (p_word) else $error("head");
endmodule
bind fadc_latch fadc_chk fadc_chk_i (.*);

// >>> testbench/flash_adc_output_latch_tb_top.sv
// Testbench for the flash converter output latch.
`timescale 1ns/1ns
module flash_adc_output_latch_tb_top
   import fadc_pkg::*;
();
   logic       clk = 0, rst_b = 0, fire = 0, stall = 0, mode = 1, top = 0;
   logic [7:0] code = 8'h00, res;
   logic       s, sn, rdy, ovr, wv, lost;
   fadc_word_s w;
   int         miscompares = 0, n_tests = 0;
   fadc_cap fadc_cap_i (.i_fire(fire), .i_stall(stall), .o_strobe(s),
      .o_strobe_n(sn), .o_ready(rdy));
   fadc_latch fadc_latch_i (.i_mclk(clk), .i_rst_b(rst_b),
      .i_sample_strobe(s), .i_sample_strobe_n(sn),
      .i_overrange_mode_select(mode), .i_conv_code(code),
      .i_conv_at_top(top), .o_result(res), .o_overrange(ovr),
      .o_word_valid(wv), .o_word(w), .i_word_ready(rdy), .o_word_lost(lost));
   initial begin
      forever #2 clk = ~clk;
   end
   task chk(input string nm, input logic [8:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task smp(input logic [7:0] c, input logic t);
      code = c;
      top = t;
      fire = 1;
      @(negedge clk) fire = 0;
      @(negedge clk);
   endtask
   task close_out;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task t_stream;
      smp(8'h01, 1'b0);
      chk("first", {res, ovr}, 9'h000);
      smp(8'h80, 1'b0);
      chk("result", {res, ovr}, 9'h002);
      $display("stream done");
   endtask
   task t_overrange;
      mode = 1'b1;
      smp(8'h5a, 1'b1);
      smp(8'h3c, 1'b0);
      chk("rtz", {res, ovr}, 9'h001);
      mode = 1'b0;
      smp(8'h5a, 1'b1);
      smp(8'h3c, 1'b0);
      chk("nrz", {res, ovr}, 9'h1fe);
      $display("overrange done");
   endtask
   task t_buffer;
      stall = 1'b1;
      smp(8'h11, 1'b0);
      smp(8'h22, 1'b0);
      smp(8'h33, 1'b0);
      chk("lost", lost, 9'h001);
      chk("head", w, 9'h078);
      stall = 1'b0;
      @(negedge clk);
      chk("second", w, 9'h022);
      chk("second valid", wv, 9'h001);
      repeat (8) if (wv) @(negedge clk);
      chk("drained", wv, 9'h000);
      $display("buffer done");
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1;
      t_stream;
      t_overrange;
      t_buffer;
      close_out;
   end
endmodule
